// ==== common/video_pkg.sv ====
// Shared constants for the text and graphics video controller and its host end
package video_pkg;
  // Documented host I/O ports and buffer window
  localparam logic [19:0] PORT_INDEX = 20'h003d4;
  localparam logic [19:0] PORT_DATA = 20'h003d5;
  localparam logic [19:0] PORT_MODE = 20'h003d8;
  localparam logic [19:0] PORT_COLOUR = 20'h003d9;
  localparam logic [19:0] BUF_BASE = 20'hb8000;
  localparam logic [19:0] BUF_LAST = 20'hbbfff;
  localparam int unsigned BUF_BYTES = 16384;
  // Controller register numbers
  localparam logic [4:0] CRTC_COUNT = 5'h12;
  localparam logic [4:0] R_HTOTAL = 5'h00;
  localparam logic [4:0] R_HDISP = 5'h01;
  localparam logic [4:0] R_HSPOS = 5'h02;
  localparam logic [4:0] R_HSWID = 5'h03;
  localparam logic [4:0] R_VTOTAL = 5'h04;
  localparam logic [4:0] R_VADJ = 5'h05;
  localparam logic [4:0] R_VDISP = 5'h06;
  localparam logic [4:0] R_VSPOS = 5'h07;
  localparam logic [4:0] R_MAXSCAN = 5'h09;
  localparam logic [4:0] R_CURST = 5'h0a;
  localparam logic [4:0] R_CUREND = 5'h0b;
  localparam logic [4:0] R_STARTH = 5'h0c;
  localparam logic [4:0] R_STARTL = 5'h0d;
  localparam logic [4:0] R_CURH = 5'h0e;
  localparam logic [4:0] R_CURL = 5'h0f;
  localparam logic [4:0] R_PENH = 5'h10;
  localparam logic [4:0] R_PENL = 5'h11;
  localparam logic [4:0] VSYNC_LINES = 5'h10;
  // Character slot: 32 cycles in 80-column timing, 64 in 40-column timing
  localparam logic [5:0] SLOT_LAST_80 = 6'h1f;
  localparam logic [5:0] SLOT_LAST_40 = 6'h3f;
  // Mode register bits
  localparam int unsigned MODE_COLS80 = 0;
  localparam int unsigned MODE_GRAPH = 1;
  localparam int unsigned MODE_MONO = 2;
  localparam int unsigned MODE_ENABLE = 3;
  localparam int unsigned MODE_HIRES = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Colour select bits
  localparam int unsigned COL_PALETTE = 5;
  localparam logic [7:0] COLOUR_RESET = 8'h00;
  // Attribute bits
  localparam int unsigned ATTR_BLINK = 7;
  localparam logic [6:0] ATTR_UNDERLINE = 7'h47;
  // Host register offsets
  localparam logic [1:0] HREG_ADDR = 2'h0;
  localparam logic [1:0] HREG_WDATA = 2'h1;
  localparam logic [1:0] HREG_CTRL = 2'h2;
  localparam logic [1:0] HREG_STATUS = 2'h3;
  localparam int unsigned CTRL_MEM = 0;
  localparam int unsigned CTRL_READ = 1;
endpackage : video_pkg

// ==== common/video_link_if.sv ====
// Link between the host end and the video controller end
`timescale 1ns/1ps
`default_nettype none
interface video_link_if;
  logic e;
  logic cs_n;
  logic index_or_data_select;
  logic rw_n;
  logic [7:0] host_dq;
  logic [7:0] dev_dq;
  logic dev_dq_oe_n;
  logic mode_wr;
  logic colour_wr;
  logic mem_req;
  logic mem_we;
  logic [13:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic mem_ack;
  modport device (
    input e, cs_n, index_or_data_select, rw_n, host_dq, mode_wr, colour_wr,
    input mem_req, mem_we, mem_addr, mem_wdata,
    output dev_dq, dev_dq_oe_n, mem_rdata, mem_ack
  );
  modport host (
    output e, cs_n, index_or_data_select, rw_n, host_dq, mode_wr, colour_wr,
    output mem_req, mem_we, mem_addr, mem_wdata,
    input dev_dq, dev_dq_oe_n, mem_rdata, mem_ack
  );
endinterface : video_link_if
`default_nettype wire

// ==== verilog/video_device.sv ====
// Video controller end: register set, display buffer, raster timing, pixels
// Notes on behaviour
// R1 - Cell is character byte even, attribute odd
// R2 - Attribute bit 7 blinks, bit 3 intensifies
// R3 - Mono attribute codes: normal, reverse, blank, underline
// R4 - Bits 6-4 background, 2-0 foreground, RGB
// R5 - Host fits eight 40-column or four 80-column pages
// R6 - Own 16 KB buffer at B8000H
// R7 - Even graphics rows low bank, odd rows high
// R8 - Medium resolution: four 2-bit pixels, MSBs left
// R9 - Code 0 background, 1-3 palette colours
// R10 - Two palettes; background any of sixteen
// R11 - High resolution: one bit per pixel
// R12 - Colour select picks high resolution lit colour
// R13 - Register access only while chip select low
// R14 - Select low hits index, high hits register
// R15 - Read/write line sets transfer direction
// R16 - Reset clears counters and outputs, keeps registers
// R17 - Drive 14-bit memory and 5-bit raster address
// R18 - Display enable low during all retrace
// R19 - Pen strobe captures memory address
// R20 - Index write-only, keeps five low bits
// R21 - Data port reaches the indexed register
// R22 - Host blanks video before reprogramming
// R23 - Refresh wins buffer; host never waits long
`timescale 1ns/1ps
`default_nettype none
module video_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host link
  video_link_if.device link,
  // Board inputs
  input wire logic crtc_reset_n,
  input wire logic pen_strobe,
  // Character generator
  input wire logic [7:0] font_row,
  output logic [7:0] char_code,
  // Raster outputs
  output logic [13:0] screen_addr,
  output logic [4:0] raster_row,
  output logic active_video,
  output logic hsync,
  output logic vsync,
  output logic cursor,
  output logic [3:0] rgbi
);
  logic [7:0] crtc [0:17];
  logic [4:0] index;
  logic [7:0] mode;
  logic [7:0] colour_select;
  logic [7:0] vram [0:video_pkg::BUF_BYTES-1];
  logic [7:0] port_q;
  logic [1:0] run_sync;
  logic [1:0] pen_sync;
  logic run;
  logic pen;
  logic [5:0] sc;
  logic slot_end;
  logic [3:0] dot;
  logic [7:0] hc;
  logic [7:0] next_hc;
  logic [4:0] ra;
  logic [4:0] next_ra;
  logic [6:0] vr;
  logic [6:0] next_vr;
  logic adj;
  logic next_adj;
  logic [13:0] row_start;
  logic [13:0] next_row_start;
  logic [13:0] ma;
  logic [13:0] start_addr;
  logic [13:0] cursor_addr;
  logic line_end;
  logic frame_end;
  logic [4:0] vs_cnt;
  logic [4:0] frames;
  logic [4:0] hs_wid;
  logic [7:0] hs_off;
  logic disp;
  logic hs;
  logic cur;
  logic refresh;
  logic grant;
  logic [13:0] fetch_addr;
  logic [13:0] port_addr;
  logic [7:0] byte1;
  logic [7:0] pix_a;
  logic [7:0] pix_b;
  logic [7:0] glyph;
  logic under_row;
  logic disp_d;
  logic [2:0] k;
  logic [1:0] code;
  logic lit;
  logic [3:0] fg;
  logic [3:0] bg;
  logic [3:0] colour;
  logic [15:0] pix_pair;

  function automatic logic [1:0] pick2(input logic [7:0] b, input logic [1:0] n);
    logic [7:0] s;
    s = b >> {~n, 1'b0};
    return s[1:0];
  endfunction : pick2

  // Board levels come from outside the clock domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_sync <= 2'h0;
      pen_sync <= 2'h0;
    end else begin
      run_sync <= {run_sync[0], crtc_reset_n};
      pen_sync <= {pen_sync[0], pen_strobe};
    end
  end
  assign run = run_sync[1];
  assign pen = pen_sync[1];

  // Controller register port; answers a read in the following cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      index <= 5'h00;
      link.dev_dq <= 8'h00;
      link.dev_dq_oe_n <= 1'b1;
      for (int i = 0; i < 18; i++) begin
        crtc[i] <= 8'h00;
      end
    end else begin
      link.dev_dq_oe_n <= 1'b1;
      if (link.e && !link.cs_n) begin // R13
        if (!link.index_or_data_select) begin // R14
          if (!link.rw_n) begin
            index <= link.host_dq[4:0]; // R20
          end
        end else if (!link.rw_n) begin // R15
          if (index < video_pkg::R_PENH) begin
            crtc[index] <= link.host_dq; // R21
          end
        end else begin
          link.dev_dq_oe_n <= 1'b0; // R15
          if (index >= video_pkg::R_CURH && index < video_pkg::CRTC_COUNT) begin
            link.dev_dq <= crtc[index]; // R21
          end else begin
            link.dev_dq <= 8'h00;
          end
        end
      end
      if (pen) begin
        crtc[video_pkg::R_PENH] <= {2'h0, ma[13:8]}; // R19
        crtc[video_pkg::R_PENL] <= ma[7:0]; // R19
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= video_pkg::MODE_RESET;
      colour_select <= video_pkg::COLOUR_RESET;
    end else begin
      if (link.mode_wr) begin
        mode <= link.host_dq;
      end
      if (link.colour_wr) begin
        colour_select <= link.host_dq; // R12
      end
    end
  end

  // Character slot divider
  assign slot_end = mode[video_pkg::MODE_COLS80] ? (sc == video_pkg::SLOT_LAST_80)
                                                 : (sc == video_pkg::SLOT_LAST_40);
  assign dot = mode[video_pkg::MODE_COLS80] ? sc[4:1] : sc[5:2];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sc <= 6'h00;
    end else if (!run || slot_end) begin
      sc <= 6'h00; // R16
    end else begin
      sc <= sc + 6'h01;
    end
  end

  assign start_addr = {crtc[video_pkg::R_STARTH][5:0], crtc[video_pkg::R_STARTL]};
  assign cursor_addr = {crtc[video_pkg::R_CURH][5:0], crtc[video_pkg::R_CURL]};
  assign ma = row_start + {6'h00, hc};

  always_comb begin
    next_hc = hc + 8'h01;
    next_ra = ra;
    next_vr = vr;
    next_adj = adj;
    next_row_start = row_start;
    frame_end = 1'b0;
    line_end = (hc == crtc[video_pkg::R_HTOTAL]);
    if (line_end) begin
      next_hc = 8'h00;
      next_ra = ra + 5'h01;
      if (adj) begin
        frame_end = (next_ra == crtc[video_pkg::R_VADJ][4:0]);
      end else if (ra == crtc[video_pkg::R_MAXSCAN][4:0]) begin
        next_ra = 5'h00;
        next_row_start = row_start + {6'h00, crtc[video_pkg::R_HDISP]};
        if (vr == crtc[video_pkg::R_VTOTAL][6:0]) begin
          if (crtc[video_pkg::R_VADJ][4:0] == 5'h00) begin
            frame_end = 1'b1;
          end else begin
            next_adj = 1'b1;
          end
        end else begin
          next_vr = vr + 7'h01;
        end
      end
      if (frame_end) begin
        next_ra = 5'h00;
        next_vr = 7'h00;
        next_adj = 1'b0;
        next_row_start = start_addr;
      end
    end
  end

  assign disp = (hc < crtc[video_pkg::R_HDISP]) && (vr < crtc[video_pkg::R_VDISP][6:0]) && !adj;
  assign hs_wid = (crtc[video_pkg::R_HSWID][3:0] == 4'h0) ? 5'h10
                                                          : {1'b0, crtc[video_pkg::R_HSWID][3:0]};
  assign hs_off = hc - crtc[video_pkg::R_HSPOS];
  assign hs = (hc >= crtc[video_pkg::R_HSPOS]) && (hs_off < {3'h0, hs_wid});
  assign cur = disp && (ma == cursor_addr) && (ra >= crtc[video_pkg::R_CURST][4:0])
               && (ra <= crtc[video_pkg::R_CUREND][4:0]);

  // Raster counters advance once per character slot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hc <= 8'h00;
      ra <= 5'h00;
      vr <= 7'h00;
      adj <= 1'b0;
      row_start <= 14'h0000;
      vs_cnt <= 5'h00;
      frames <= 5'h00;
    end else if (!run) begin
      hc <= 8'h00; // R16
      ra <= 5'h00;
      vr <= 7'h00;
      adj <= 1'b0;
      row_start <= 14'h0000;
      vs_cnt <= 5'h00;
      frames <= 5'h00;
    end else if (slot_end) begin
      hc <= next_hc;
      ra <= next_ra;
      vr <= next_vr;
      adj <= next_adj;
      row_start <= next_row_start;
      if (frame_end) begin
        frames <= frames + 5'h01;
      end
      if (line_end) begin
        if (vs_cnt != 5'h00) begin
          vs_cnt <= vs_cnt - 5'h01;
        end else if (next_vr == crtc[video_pkg::R_VSPOS][6:0] && next_ra == 5'h00 && !next_adj) begin
          vs_cnt <= video_pkg::VSYNC_LINES;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      screen_addr <= 14'h0000;
      raster_row <= 5'h00;
      active_video <= 1'b0;
      hsync <= 1'b0;
      vsync <= 1'b0;
      cursor <= 1'b0;
    end else if (!run) begin
      screen_addr <= 14'h0000; // R16
      raster_row <= 5'h00;
      active_video <= 1'b0;
      hsync <= 1'b0;
      vsync <= 1'b0;
      cursor <= 1'b0;
    end else begin
      screen_addr <= ma; // R17
      raster_row <= ra; // R17
      active_video <= disp; // R18
      hsync <= hs;
      vsync <= (vs_cnt != 5'h00);
      cursor <= cur;
    end
  end

  // Single buffer port: refresh owns slot cycles 0 and 1, host takes the rest
  assign refresh = run && (sc < 6'h02); // R23
  assign grant = link.mem_req && !link.mem_ack && !refresh; // R23
  assign fetch_addr = mode[video_pkg::MODE_GRAPH] ? {ra[0], ma[11:0], sc[0]} // R7
                                                  : {ma[12:0], sc[0]}; // R1
  assign port_addr = grant ? link.mem_addr : fetch_addr;
  always_ff @(posedge clk) begin
    if (grant && link.mem_we) begin
      vram[port_addr] <= link.mem_wdata; // R6
    end
    port_q <= vram[port_addr];
  end
  assign link.mem_rdata = port_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.mem_ack <= 1'b0;
    end else begin
      link.mem_ack <= grant;
    end
  end

  // Fetched bytes are shown during the following slot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      char_code <= 8'h00;
      byte1 <= 8'h00;
      pix_a <= 8'h00;
      pix_b <= 8'h00;
      glyph <= 8'h00;
      under_row <= 1'b0;
      disp_d <= 1'b0;
    end else if (!run) begin
      char_code <= 8'h00;
      disp_d <= 1'b0;
    end else begin
      if (sc == 6'h01) begin
        char_code <= port_q;
      end
      if (sc == 6'h02) begin
        byte1 <= port_q;
      end
      if (slot_end) begin
        pix_a <= char_code;
        pix_b <= byte1;
        glyph <= font_row;
        under_row <= (ra == crtc[video_pkg::R_MAXSCAN][4:0]);
        disp_d <= disp && mode[video_pkg::MODE_ENABLE];
      end
    end
  end

  // High resolution: both fetched bytes form sixteen dots, MSB of the first leftmost
  assign pix_pair = {pix_a, pix_b};

  always_comb begin
    k = dot[3:1];
    code = pick2(k[2] ? pix_b : pix_a, k[1:0]); // R8
    fg = {pix_b[2:0], pix_b[3]}; // R4
    bg = {pix_b[6:4], 1'b0}; // R4
    lit = glyph[~k];
    if (mode[video_pkg::MODE_MONO]
        && {pix_b[6:4], 1'b0, pix_b[2:0]} == video_pkg::ATTR_UNDERLINE) begin
      bg = 4'h0; // R3
      lit = lit | under_row; // R3
    end
    if (pix_b[video_pkg::ATTR_BLINK] && frames[4]) begin
      lit = 1'b0; // R2
    end
    if (!mode[video_pkg::MODE_GRAPH]) begin
      colour = lit ? fg : bg; // R2
    end else if (mode[video_pkg::MODE_HIRES]) begin
      colour = pix_pair[~dot] ? {colour_select[2:0], colour_select[3]} : 4'h0; // R11
    end else if (code == 2'h0) begin
      colour = {colour_select[2:0], colour_select[3]}; // R9
    end else begin
      colour = {code[1], code[0], colour_select[video_pkg::COL_PALETTE], 1'b0}; // R10
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rgbi <= 4'h0;
    end else if (!run || !disp_d) begin
      rgbi <= 4'h0; // R18
    end else begin
      rgbi <= colour;
    end
  end
endmodule : video_device
`default_nettype wire

// ==== verilog/video_host.sv ====
// Host end: command registers that drive controller ports and buffer accesses
`timescale 1ns/1ps
`default_nettype none
module video_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Software register port
  input wire logic [1:0] addr,
  input wire logic [19:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [19:0] rdata,
  // Link to the controller
  video_link_if.host link
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_IO = 4'h2,
    ST_RDWAIT = 4'h4,
    ST_MEM = 4'h8
  } host_state_e;

  host_state_e state;
  logic [19:0] target;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic err;
  logic launch;
  logic is_read;
  logic in_buf;

  assign launch = wr && (addr == video_pkg::HREG_CTRL) && (state == ST_IDLE);
  assign is_read = wdata[video_pkg::CTRL_READ];
  assign in_buf = (target >= video_pkg::BUF_BASE) && (target <= video_pkg::BUF_LAST); // R6

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      target <= 20'h00000;
      wbyte <= 8'h00;
    end else if (wr && addr == video_pkg::HREG_ADDR) begin
      target <= wdata;
    end else if (wr && addr == video_pkg::HREG_WDATA) begin
      wbyte <= wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 20'h00000;
    end else if (rd) begin
      if (addr == video_pkg::HREG_STATUS) begin
        rdata <= {10'h000, err, state != ST_IDLE, rbyte};
      end else if (addr == video_pkg::HREG_ADDR) begin
        rdata <= target;
      end else if (addr == video_pkg::HREG_WDATA) begin
        rdata <= {12'h000, wbyte};
      end else begin
        rdata <= 20'h00000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      err <= 1'b0;
      rbyte <= 8'h00;
      link.e <= 1'b0;
      link.cs_n <= 1'b1;
      link.index_or_data_select <= 1'b0;
      link.rw_n <= 1'b1;
      link.host_dq <= 8'h00;
      link.mode_wr <= 1'b0;
      link.colour_wr <= 1'b0;
      link.mem_req <= 1'b0;
      link.mem_we <= 1'b0;
      link.mem_addr <= 14'h0000;
      link.mem_wdata <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            err <= 1'b0;
            link.host_dq <= wbyte;
            if (wdata[video_pkg::CTRL_MEM]) begin
              if (in_buf) begin
                link.mem_req <= 1'b1;
                link.mem_we <= !is_read;
                link.mem_addr <= target[13:0];
                link.mem_wdata <= wbyte;
                state <= ST_MEM;
              end else begin
                err <= 1'b1;
              end
            end else if (target == video_pkg::PORT_INDEX && !is_read) begin
              link.e <= 1'b1; // R13
              link.cs_n <= 1'b0;
              link.index_or_data_select <= 1'b0; // R20
              link.rw_n <= 1'b0;
              state <= ST_IO;
            end else if (target == video_pkg::PORT_DATA) begin
              link.e <= 1'b1; // R13
              link.cs_n <= 1'b0;
              link.index_or_data_select <= 1'b1; // R21
              link.rw_n <= is_read; // R15
              state <= ST_IO;
            end else if (target == video_pkg::PORT_MODE && !is_read) begin
              link.mode_wr <= 1'b1;
              state <= ST_IO;
            end else if (target == video_pkg::PORT_COLOUR && !is_read) begin
              link.colour_wr <= 1'b1; // R12
              state <= ST_IO;
            end else begin
              err <= 1'b1;
            end
          end
        end
        ST_IO: begin
          link.e <= 1'b0;
          link.cs_n <= 1'b1;
          link.mode_wr <= 1'b0;
          link.colour_wr <= 1'b0;
          state <= (link.cs_n == 1'b0 && link.rw_n) ? ST_RDWAIT : ST_IDLE;
          link.rw_n <= 1'b1;
        end
        ST_RDWAIT: begin
          rbyte <= link.dev_dq_oe_n ? 8'h00 : link.dev_dq;
          state <= ST_IDLE;
        end
        ST_MEM: begin
          if (link.mem_ack) begin
            link.mem_req <= 1'b0;
            if (!link.mem_we) begin
              rbyte <= link.mem_rdata;
            end
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : video_host
`default_nettype wire

// ==== sim/video_checker.sv ====
// Link protocol checks between the host end and the controller end
`timescale 1ns/1ps
`default_nettype none
module video_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic e,
  input wire logic cs_n,
  input wire logic rw_n,
  input wire logic dev_dq_oe_n,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [13:0] mem_addr,
  input wire logic mem_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_read_drives_bus: assert property (e && !cs_n && rw_n |=> !dev_dq_oe_n)
    else $error("read access not answered next cycle");
  a_bus_idle_otherwise: assert property (!(e && !cs_n && rw_n) |=> dev_dq_oe_n)
    else $error("data bus driven without a selected read");
  a_oe_single_cycle: assert property (!dev_dq_oe_n |=> dev_dq_oe_n)
    else $error("data bus driven longer than one cycle");
  a_select_with_strobe: assert property (e |-> !cs_n ##1 !e)
    else $error("access strobe without select or longer than one cycle");
  a_ack_within_three: assert property ($rose(mem_req) |-> ##[1:3] mem_ack)
    else $error("buffer access not granted within three cycles");
  a_ack_needs_req: assert property (mem_ack |-> mem_req ##1 (!mem_ack && !mem_req))
    else $error("buffer acknowledge without request or not one cycle");
  a_req_held_stable: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("buffer request changed before acknowledge");

  c_buf_write: cover property (mem_ack && mem_we);
  c_buf_read: cover property (mem_ack && !mem_we);
  c_reg_read: cover property (!dev_dq_oe_n);
endmodule : video_checker
`default_nettype wire

// ==== sim/test_text_graphics_video_controller.sv ====
// Bench for the host and controller ends joined by the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module test_text_graphics_video_controller;
  logic clk, rst, wr, rd, crtc_reset_n, pen_strobe;
  logic [1:0] addr;
  logic [19:0] wdata, rdata, st;
  logic [7:0] char_code, last_colour, last_mode;
  logic [13:0] screen_addr, last_maddr;
  logic [4:0] raster_row;
  logic active_video, hsync, vsync, cursor;
  logic [3:0] rgbi;
  int err_count = 0, total_checks = 0, n_ack = 0, n_active = 0, bad_blank = 0, bad_row = 0;
  int n_fg = 0, n_bg = 0, n_brown = 0;
  int n0;
  logic [19:0] baddr [3] = '{20'hb8000, 20'hb8001, 20'hbbfff};
  logic [7:0] bdata [3] = '{8'h41, 8'h1e, 8'ha5};
  logic [7:0] pidx [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09};
  logic [7:0] pval [9] = '{8'h0f, 8'h0a, 8'h0c, 8'h02, 8'h0f, 8'h00, 8'h04, 8'h05, 8'h01};

  video_link_if link ();
  video_device video_device_inst (.clk(clk), .rst(rst), .link(link),
    .crtc_reset_n(crtc_reset_n), .pen_strobe(pen_strobe), .font_row(8'h81),
    .char_code(char_code), .screen_addr(screen_addr), .raster_row(raster_row),
    .active_video(active_video), .hsync(hsync), .vsync(vsync), .cursor(cursor), .rgbi(rgbi));
  video_host video_host_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link(link));
  video_checker video_checker_inst (.clk(clk), .rst(rst), .e(link.e), .cs_n(link.cs_n),
    .rw_n(link.rw_n), .dev_dq_oe_n(link.dev_dq_oe_n), .mem_req(link.mem_req),
    .mem_we(link.mem_we), .mem_addr(link.mem_addr), .mem_ack(link.mem_ack));

  always #10 clk = ~clk;

  // Link and raster observation
  always @(posedge clk) begin
    if (link.mem_ack) begin
      n_ack++;
      last_maddr = link.mem_addr;
    end
    if (link.colour_wr) last_colour = link.host_dq;
    if (link.mode_wr) last_mode = link.host_dq;
    if ((hsync || vsync) && active_video) bad_blank++;
    if (active_video) n_active++;
    if (raster_row > 5'h01) bad_row++;
    if (cursor && !active_video) bad_blank++;
    if (rgbi === 4'hd) n_fg++;
    if (rgbi === 4'h2) n_bg++;
    if (rgbi === 4'hc) n_brown++;
  end

  task automatic hwr(input logic [1:0] a, input logic [19:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : hwr

  task automatic hrd(input logic [1:0] a, output logic [19:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : hrd

  // One launched transfer, then status polled until not busy
  task automatic io(input logic [19:0] port, input logic [7:0] d, input logic rdn,
      input logic mem, output logic [19:0] s);
    hwr(video_pkg::HREG_ADDR, port);
    hwr(video_pkg::HREG_WDATA, {12'h000, d});
    hwr(video_pkg::HREG_CTRL, {18'h00000, rdn, mem});
    for (int i = 0; i < 40; i++) begin
      hrd(video_pkg::HREG_STATUS, s);
      if (s[8] === 1'b0) break;
      if (i == 39) `CHK(s[8], 1'b0)
    end
  endtask : io

  task automatic end_sim;
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial begin
    #900_000;
    err_count++;
    end_sim();
  end

  initial begin
    clk = 0; rst = 1; wr = 0; rd = 0; addr = '0; wdata = '0;
    crtc_reset_n = 1; pen_strobe = 0;
    repeat (20) @(posedge clk);
    rst <= 0;
    hrd(video_pkg::HREG_STATUS, st);
    `CHK(st, 20'h00000)
    io(video_pkg::PORT_INDEX, 8'h2e, 0, 0, st);
    io(video_pkg::PORT_DATA, 8'h3a, 0, 0, st);
    io(video_pkg::PORT_INDEX, 8'h0f, 0, 0, st);
    io(video_pkg::PORT_DATA, 8'h15, 0, 0, st);
    io(video_pkg::PORT_INDEX, 8'h0e, 0, 0, st);
    io(video_pkg::PORT_DATA, 8'h00, 1, 0, st);
    `CHK(st[9:0], 10'h03a)
    io(video_pkg::PORT_INDEX, 8'h0f, 0, 0, st);
    io(video_pkg::PORT_DATA, 8'h00, 1, 0, st);
    `CHK(st[9:0], 10'h015)
    io(video_pkg::PORT_INDEX, 8'h0c, 0, 0, st);
    io(video_pkg::PORT_DATA, 8'h55, 0, 0, st);
    io(video_pkg::PORT_DATA, 8'h00, 1, 0, st);
    `CHK(st[9:0], 10'h000)
    io(video_pkg::PORT_INDEX, 8'h00, 1, 0, st);
    `CHK(st[9], 1'b1)
    io(video_pkg::PORT_MODE, 8'h00, 0, 0, st);
    `CHK(last_mode, 8'h00)
    io(video_pkg::PORT_COLOUR, 8'h0f, 0, 0, st);
    `CHK(last_colour, 8'h0f)
    for (int i = 0; i < 3; i++) io(baddr[i], bdata[i], 0, 1, st);
    for (int i = 0; i < 3; i++) begin
      io(baddr[i], 8'h00, 1, 1, st);
      `CHK(st[9:0], {2'b00, bdata[i]})
      `CHK(last_maddr, baddr[i][13:0])
    end
    n0 = n_ack;
    io(20'hbc000, 8'h77, 0, 1, st);
    `CHK(st[9], 1'b1)
    `CHK(n_ack, n0)
    io(20'hbbe7f, 8'h5a, 0, 1, st);
    io(20'hbbe7f, 8'h00, 1, 1, st);
    `CHK(st[9:0], 10'h05a)
    // Timing is programmed with the raster held in reset
    @(posedge clk);
    crtc_reset_n <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      io(video_pkg::PORT_INDEX, pidx[i], 0, 0, st);
      io(video_pkg::PORT_DATA, pval[i], 0, 0, st);
    end
    io(video_pkg::PORT_MODE, 8'h09, 0, 0, st);
    `CHK(last_mode, 8'h09)
    @(posedge clk);
    crtc_reset_n <= 1'b1;
    repeat (20000) @(posedge clk);
    `CHK(bad_blank, 0)
    `CHK(n_active != 0, 1'b1)
    `CHK(bad_row, 0)
    `CHK(n_fg != 0, 1'b1)
    `CHK(n_bg != 0, 1'b1)
    pen_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    pen_strobe <= 1'b0;
    io(video_pkg::PORT_INDEX, 8'h10, 0, 0, st);
    io(video_pkg::PORT_DATA, 8'h00, 1, 0, st);
    `CHK(st[9:0], 10'h015)
    crtc_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1 `CHK({screen_addr, raster_row, active_video, rgbi, char_code}, 32'h0)
    io(video_pkg::PORT_MODE, 8'h0b, 0, 0, st);
    @(posedge clk);
    crtc_reset_n <= 1'b1;
    io(video_pkg::PORT_INDEX, 8'h0e, 0, 0, st);
    io(video_pkg::PORT_DATA, 8'h00, 1, 0, st);
    `CHK(st[9:0], 10'h03a)
    repeat (600) @(posedge clk);
    `CHK(n_brown != 0, 1'b1)
    end_sim();
  end
endmodule : test_text_graphics_video_controller
`default_nettype wire
